// File: core/pmr_pick.sv
/*
 * pmr_pick: chooses one motor out of a candidate mask, by number or by
 * cumulative runtime.
 * Assumes runtimes packed motor 0 in the low word.
 */
`timescale 1ns/100ps
`default_nettype none
module pmr_pick
	import pmr_pkg::*;
#(
	parameter int N  = 4,
	parameter int W  = 32,
	parameter int IW = 2
) (
	// selection
	input  wire logic [N-1:0]   cand_i,
	input  wire logic [N*W-1:0] rt_i,
	input  wire pmr_pick_t      how_i,
	input  wire logic [IW-1:0]  base_i,
	// result
	output logic                found_o,
	output logic [IW-1:0]       idx_o
);
	int         j;
	logic [W-1:0] v;
	logic [W-1:0] best;

	// ties go to the smaller motor number: strict compare, ascending scan
	always_comb begin
		found_o = 1'b0;
		idx_o   = '0;
		best    = '0;
		j       = 0;
		v       = '0;
		for (int k = 0; k < N; k++) begin
			j = int'(base_i) + k;
			if (j >= N) begin
				j = j - N;
			end
			v = rt_i[k*W +: W];
			unique case (how_i)
				PK_LOW: if (cand_i[j] && !found_o) begin
					found_o = 1'b1;
					idx_o   = IW'(j);
				end
				PK_HIGH: if (cand_i[k]) begin
					found_o = 1'b1;
					idx_o   = IW'(k);
				end
				PK_MIN: if (cand_i[k] && (!found_o || v < best)) begin
					found_o = 1'b1;
					idx_o   = IW'(k);
					best    = v;
				end
				PK_MAX: if (cand_i[k] && (!found_o || v > best)) begin
					found_o = 1'b1;
					idx_o   = IW'(k);
					best    = v;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: core/pmr_pkg.sv
/*
 * pmr_pkg: constants, register map and shared types of the pump motor
 * rotation sequencer.
 * Assumes a single 100 MHz clock and a classic Wishbone register bus.
 */
// Contract
// RQ1 - order 0: start next motor in ascending order
// RQ2 - order 0: stop highest-numbered running motor first
// RQ3 - order 1: start stopped motor with least runtime
// RQ4 - order 1: stop running motor with most runtime
// RQ5 - order 2 as 0, slow-flow advances drive role
// RQ6 - order 3 as 1, slow-flow gives least-runtime drive
// RQ7 - run off: drive decelerates, selects drop at stop
// RQ8 - alarm: drive output and selects cut at once
// RQ9 - stop setting 0: mains drop when drive stops
// RQ10 - setting 1: run off keeps mains, alarm drops
// RQ11 - setting 2: mains kept on run off, alarm
// RQ12 - motor disabled or unpermitted: its mains contactor drops
// RQ13 - control disabled or coast: all mains drop
// RQ14 - mode and enable writable only while stopped
// RQ15 - stable interval elapsed: swap running for stopped motor
// RQ16 - target 1: rotate drive-fed motor
// RQ17 - target 2: rotate mains-fed motors
// RQ18 - target 3: rotate all motors
// RQ19 - fixed drive mode rotates mains motors, target 2
// RQ20 - interval in 0.1 h steps, max 720.0 h
// RQ21 - interval 0.0 disables rotation
// RQ22 - interval 999 means three minutes
// RQ23 - forecast output for programmed time, then swap
// RQ24 - rotation stops most runtime, starts least runtime
// RQ25 - forced mains motors never rotated
// RQ26 - per-motor runtime counter advanced by time tick
//
package pmr_pkg;

	// ==================================================================
	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_MS = 10;
	localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int ROT_STEP_MS    = 360000;
	localparam int ROT_FAST_MS    = 180000;
	localparam int ROT_STEP_TICKS = ROT_STEP_MS / TICK_PERIOD_MS;
	localparam int ROT_FAST_TICKS = ROT_FAST_MS / TICK_PERIOD_MS;
	localparam logic [15:0] ROT_MAX_TENTHS = 16'h1c20;
	localparam logic [15:0] ROT_FAST_CODE  = 16'h2706;

	// ==================================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SEQ  = 8'h04;
	localparam logic [7:0] OFS_ROT  = 8'h08;
	localparam logic [7:0] OFS_FCST = 8'h0c;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_RT   = 8'h20;

	// ==================================================================
	// field positions
	localparam int CTRL_EN_POS   = 0;
	localparam int CTRL_MODE_POS = 8;
	localparam int SEQ_ORD_POS   = 0;
	localparam int SEQ_STOP_POS  = 4;
	localparam int SEQ_TGT_POS   = 8;
	localparam int STAT_MNS_POS  = 8;
	localparam int STAT_FC_POS   = 16;

	// ==================================================================
	// reset values
	localparam logic [7:0]  RST_MODE   = 8'h00;
	localparam logic [1:0]  RST_ORDER  = 2'h0;
	localparam logic [1:0]  RST_STOP   = 2'h0;
	localparam logic [1:0]  RST_TARGET = 2'h1;
	localparam logic [15:0] RST_ROT    = 16'h0000;
	localparam logic [15:0] RST_FCST   = 16'h0000;

	// pump control mode codes, per-motor mode codes
	localparam logic [7:0] PCM_OFF   = 8'h00;
	localparam logic [7:0] PCM_FIXED = 8'h01;
	localparam logic [1:0] MM_OFF    = 2'h0;
	localparam logic [1:0] MM_ON     = 2'h1;
	localparam logic [1:0] MM_FORCED = 2'h2;

	// ==================================================================
	// types
	typedef struct packed {
		logic        pump_control_enable;
		logic [7:0]  pump_control_mode;
		logic [1:0]  switching_order_sel;
		logic [1:0]  mains_motor_stop_sel;
		logic [1:0]  rotation_target_sel;
		logic [15:0] rotation_interval;
		logic [15:0] forecast_pulse_time;
	} pmr_cfg_t;

	typedef enum logic [1:0] {PK_LOW, PK_HIGH, PK_MIN, PK_MAX} pmr_pick_t;

endpackage

// File: core/pmr_seq.sv
/*
 * pmr_seq: pump motor rotation sequencer top. Picks motors to add, shed
 * and rotate, drives drive-fed and mains-fed contactor selects.
 * Assumes synchronous inputs, one 100 MHz clock, classic Wishbone master.
 */
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pmr_seq
	import pmr_pkg::*;
#(
	parameter int N         = 4,
	parameter int TICK_DIV  = TICK_CYCLES
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// wishbone slave
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [7:0]   adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	output logic [31:0]       dat_o,
	output logic              ack_o,
	// drive status and demand
	input  wire logic         run_cmd_i,
	input  wire logic         alarm_i,
	input  wire logic         drive_stopped_i,
	input  wire logic         motor_add_i,
	input  wire logic         motor_shed_i,
	input  wire logic         slow_flow_stop_i,
	input  wire logic         coast_stop_input_i,
	input  wire logic [N-1:0] motor_drive_permit_i,
	// contactors and switch forecast output
	output logic [N-1:0]      motor_drive_fed_sel_o,
	output logic [N-1:0]      motor_mains_fed_sel_o,
	output logic              switch_forecast_out_o
);
	localparam int IW = (N > 1) ? $clog2(N) : 1;
	localparam int RW = 32;

	// ==================================================================
	// state
	pmr_cfg_t          cfg_ff;
	logic [2*N-1:0]    mmode_ff;
	logic [N*RW-1:0]   rt_ff;
	logic [N-1:0]      drv_ff;
	logic [N-1:0]      mns_ff;
	logic [N-1:0]      nxt_drv;
	logic [N-1:0]      nxt_mns;
	logic [27:0]       rot_cnt_ff;
	logic [15:0]       fc_cnt_ff;
	logic              fcst_ff;
	logic [IW:0]       cnt_prev_ff;
	logic [IW:0]       run_cnt;
	logic              tick;

	// ==================================================================
	// derived conditions
	logic [N-1:0] on_m;
	logic [N-1:0] forced_m;
	logic [N-1:0] elig;
	logic [N-1:0] stopped_m;
	logic         ctl_off;
	logic         stopped;
	logic         floating;
	logic         equal_time;
	logic [1:0]   tgt;
	logic [27:0]  rot_lim;
	logic         rot_due;
	logic         ev_rot;
	logic [IW-1:0] drv_idx;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			on_m[i]     = mmode_ff[2*i +: 2] == MM_ON;
			forced_m[i] = mmode_ff[2*i +: 2] == MM_FORCED;
		end
	end

	assign ctl_off   = !cfg_ff.pump_control_enable ||
		cfg_ff.pump_control_mode == PCM_OFF || coast_stop_input_i;
	assign elig      = on_m & motor_drive_permit_i & {N{!ctl_off}};
	assign stopped_m = elig & ~drv_ff & ~mns_ff;
	assign stopped   = !run_cmd_i && drv_ff == '0;
	assign floating  = cfg_ff.pump_control_mode != PCM_FIXED;
	assign equal_time = cfg_ff.switching_order_sel[0];
	// fixed drive motor mode always rotates mains motors
	assign tgt = floating ? cfg_ff.rotation_target_sel : 2'h2; // RQ19

	always_comb begin
		run_cnt = '0;
		drv_idx = '0;
		for (int i = 0; i < N; i++) begin
			run_cnt = run_cnt + (IW+1)'(drv_ff[i] | mns_ff[i]);
			if (drv_ff[i]) begin
				drv_idx = IW'(i);
			end
		end
	end

	// ==================================================================
	// pickers
	pmr_pick_t    how_start;
	pmr_pick_t    how_stop;
	logic [IW-1:0] base_start;
	logic [N-1:0] stop_cand;
	logic         start_ok;
	logic         stop_ok;
	logic [IW-1:0] start_idx;
	logic [IW-1:0] stop_idx;

	always_comb begin
		base_start = '0;
		how_start  = PK_LOW; // RQ1
		how_stop   = PK_HIGH; // RQ2
		stop_cand  = mns_ff & on_m;
		if (equal_time || fcst_ff) begin
			how_start = PK_MIN; // RQ3 RQ24
			how_stop  = PK_MAX; // RQ4 RQ24
		end
		if (slow_flow_stop_i && !equal_time) begin
			base_start = IW'((int'(drv_idx) + 1) % N); // RQ5
		end
		if (fcst_ff) begin
			// forced motors are never candidates for rotation
			unique case (tgt)
				2'h1:    stop_cand = drv_ff & on_m; // RQ16 RQ25
				2'h3:    stop_cand = (drv_ff | mns_ff) & on_m; // RQ18
				default: stop_cand = mns_ff & on_m; // RQ17
			endcase
		end
	end

	pmr_pick #(.N(N), .W(RW), .IW(IW)) u_start (
		.cand_i  (stopped_m),
		.rt_i    (rt_ff),
		.how_i   (how_start),
		.base_i  (base_start),
		.found_o (start_ok),
		.idx_o   (start_idx)
	);

	pmr_pick #(.N(N), .W(RW), .IW(IW)) u_stop (
		.cand_i  (stop_cand),
		.rt_i    (rt_ff),
		.how_i   (how_stop),
		.base_i  ({IW{1'b0}}),
		.found_o (stop_ok),
		.idx_o   (stop_idx)
	);

	pmr_tick #(.DIV(TICK_DIV)) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	// ==================================================================
	// contactor next state
	logic [N-1:0] one_start;
	logic [N-1:0] one_stop;
	logic         active;

	assign one_start = N'(1) << start_idx;
	assign one_stop  = N'(1) << stop_idx;
	assign active    = run_cmd_i && !alarm_i && !ctl_off;

	always_comb begin
		nxt_drv = drv_ff;
		nxt_mns = mns_ff;
		if (ev_rot && stop_ok && start_ok) begin
			// swap within the role the outgoing motor held
			if ((one_stop & drv_ff) != '0) begin
				nxt_drv = one_start; // RQ15
			end else begin
				nxt_mns = (mns_ff & ~one_stop) | one_start; // RQ15
			end
		end else if (active && motor_add_i && start_ok) begin
			if (drv_ff == '0) begin
				nxt_drv = one_start;
			end else if (floating) begin
				nxt_mns = mns_ff | drv_ff;
				nxt_drv = one_start;
			end else begin
				nxt_mns = mns_ff | one_start;
			end
		end else if (active && motor_shed_i && stop_ok) begin
			nxt_mns = mns_ff & ~one_stop;
		end else if (active && slow_flow_stop_i && start_ok &&
				cfg_ff.switching_order_sel[1] && drv_ff != '0) begin
			nxt_drv = one_start; // RQ5 RQ6
		end
		if (alarm_i) begin
			nxt_drv = '0; // RQ8
			if (cfg_ff.mains_motor_stop_sel != 2'h2) begin
				nxt_mns = '0; // RQ9 RQ10 RQ11
			end
		end else if (!run_cmd_i && drive_stopped_i) begin
			// selects held through deceleration; drive select dropped with the output, mains too in stop setting 0
			nxt_drv = '0; // RQ7
			if (cfg_ff.mains_motor_stop_sel == 2'h0) begin
				nxt_mns = '0; // RQ9 RQ10 RQ11
			end
		end
		nxt_drv = nxt_drv & elig; // RQ12
		nxt_mns = (nxt_mns & elig) | (forced_m & motor_drive_permit_i); // RQ12
		if (ctl_off) begin
			nxt_drv = '0;
			nxt_mns = '0; // RQ13
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_ff <= '0;
			mns_ff <= '0;
		end else begin
			drv_ff <= nxt_drv;
			mns_ff <= nxt_mns;
		end
	end

	assign motor_drive_fed_sel_o = drv_ff;
	assign motor_mains_fed_sel_o = mns_ff;

	// ==================================================================
	// runtime counters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rt_ff <= '0;
		end else if (tick) begin
			for (int i = 0; i < N; i++) begin
				if (drv_ff[i] || mns_ff[i]) begin
					rt_ff[i*RW +: RW] <= rt_ff[i*RW +: RW] + RW'(1); // RQ26
				end
			end
		end
	end

	// ==================================================================
	// periodic rotation
	always_comb begin
		if (cfg_ff.rotation_interval == ROT_FAST_CODE) begin
			rot_lim = 28'(ROT_FAST_TICKS); // RQ22
		end else if (cfg_ff.rotation_interval > ROT_MAX_TENTHS) begin
			rot_lim = 28'(ROT_MAX_TENTHS) * 28'(ROT_STEP_TICKS);
		end else begin
			rot_lim = 28'(cfg_ff.rotation_interval) * 28'(ROT_STEP_TICKS); // RQ20
		end
	end

	assign rot_due = tick && rot_cnt_ff + 28'h1 >= rot_lim;
	assign ev_rot  = fcst_ff && tick &&
		fc_cnt_ff >= cfg_ff.forecast_pulse_time; // RQ23

	// count changes, an empty plant or a zero setting restart the wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_prev_ff <= '0;
		end else begin
			cnt_prev_ff <= run_cnt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || run_cnt != cnt_prev_ff || run_cnt == '0 ||
				cfg_ff.rotation_interval == '0 || fcst_ff) begin
			rot_cnt_ff <= '0; // RQ21
		end else if (tick) begin
			rot_cnt_ff <= rot_cnt_ff + 28'h1; // RQ15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || ev_rot || !active) begin
			fcst_ff   <= 1'b0;
			fc_cnt_ff <= '0;
		end else if (!fcst_ff && rot_due && run_cnt == cnt_prev_ff &&
				run_cnt != '0 && cfg_ff.rotation_interval != '0) begin
			fcst_ff   <= 1'b1; // RQ23
			fc_cnt_ff <= '0;
		end else if (fcst_ff && tick) begin
			fc_cnt_ff <= fc_cnt_ff + 16'h1;
		end
	end

	assign switch_forecast_out_o = fcst_ff;

	// ==================================================================
	// wishbone register file
	logic        req;
	logic        wr;
	logic [31:0] wm;
	logic [31:0] rd;
	logic [31:0] ctrl_w;
	logic [31:0] seq_w;

	assign req = cyc_i && stb_i;
	// write lands on the edge that the master samples ack
	assign wr  = req && we_i && ack_o;
	assign wm  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign ctrl_w = (rd & ~wm) | (dat_i & wm);
	assign seq_w  = ctrl_w;

	always_comb begin
		rd = '0;
		unique case (adr_i)
			OFS_CTRL: begin
				rd[CTRL_EN_POS]        = cfg_ff.pump_control_enable;
				rd[CTRL_MODE_POS +: 8] = cfg_ff.pump_control_mode;
			end
			OFS_SEQ: begin
				rd[SEQ_ORD_POS +: 2]  = cfg_ff.switching_order_sel;
				rd[SEQ_STOP_POS +: 2] = cfg_ff.mains_motor_stop_sel;
				rd[SEQ_TGT_POS +: 2]  = cfg_ff.rotation_target_sel;
			end
			OFS_ROT:  rd[15:0] = cfg_ff.rotation_interval;
			OFS_FCST: rd[15:0] = cfg_ff.forecast_pulse_time;
			OFS_MODE: rd[2*N-1:0] = mmode_ff;
			OFS_STAT: begin
				rd[N-1:0]                = drv_ff;
				rd[STAT_MNS_POS +: N]    = mns_ff;
				rd[STAT_FC_POS]          = fcst_ff;
			end
			default: begin
				for (int i = 0; i < N; i++) begin
					if (adr_i == OFS_RT + 8'(4*i)) begin
						rd = rt_ff[i*RW +: RW];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req && !ack_o;
			dat_o <= (req && !ack_o) ? rd : '0;
		end
	end

	// one process writes the whole config struct, so it has one driver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff.pump_control_enable  <= 1'b0;
			cfg_ff.pump_control_mode    <= RST_MODE;
			cfg_ff.switching_order_sel  <= RST_ORDER;
			cfg_ff.mains_motor_stop_sel <= RST_STOP;
			cfg_ff.rotation_target_sel  <= RST_TARGET;
			cfg_ff.rotation_interval    <= RST_ROT;
			cfg_ff.forecast_pulse_time  <= RST_FCST;
			mmode_ff                    <= '0;
		end else if (wr) begin
			if (adr_i == OFS_CTRL && stopped) begin
				cfg_ff.pump_control_enable <= ctrl_w[CTRL_EN_POS]; // RQ14
				cfg_ff.pump_control_mode   <= ctrl_w[CTRL_MODE_POS +: 8]; // RQ14
			end
			if (adr_i == OFS_SEQ) begin
				cfg_ff.switching_order_sel  <= seq_w[SEQ_ORD_POS +: 2];
				cfg_ff.mains_motor_stop_sel <= seq_w[SEQ_STOP_POS +: 2];
				cfg_ff.rotation_target_sel  <= seq_w[SEQ_TGT_POS +: 2];
			end
			if (adr_i == OFS_ROT) begin
				cfg_ff.rotation_interval <= seq_w[15:0];
			end
			if (adr_i == OFS_FCST) begin
				cfg_ff.forecast_pulse_time <= seq_w[15:0];
			end
			if (adr_i == OFS_MODE) begin
				mmode_ff <= seq_w[2*N-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// File: core/pmr_tick.sv
/*
 * pmr_tick: free-running divider giving a one-cycle enable pulse.
 * Assumes the synchronous active-high reset of the block.
 */
`timescale 1ns/100ps
`default_nettype none
module pmr_tick #(
	parameter int DIV = 1000000
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pulse
	output logic      tick_o
);
	localparam int CW = $clog2(DIV + 1);

	logic [CW-1:0] cnt_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_ff == CW'(DIV - 1)) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt_ff == CW'(DIV - 1));
		end
	end
endmodule
`default_nettype wire

// File: dv/pmr_drive_model.sv
/* pmr_drive_model: drive output stage behind the drive-fed contactor.
   assumes the sequencer clock; decel length is a plain count. */
`timescale 1ns/100ps
`default_nettype none
module pmr_drive_model #(
	parameter int DECEL = 8
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// commands
	input wire logic       run_cmd_i,
	input wire logic       alarm_i,
	input wire logic [3:0] drive_sel_i,
	// status
	output logic           drive_stopped_o
);
	logic [7:0] cnt_ff;
	// ==================================================================
	// deceleration: with a drive select and no alarm, output stops when the ramp has run out
	always_ff @(posedge clk_i) begin
		if (rst_i || (run_cmd_i && !alarm_i)) begin
			cnt_ff <= 8'(DECEL);
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end
	// alarm cuts the output at once, no ramp
	assign drive_stopped_o = alarm_i || cnt_ff == 8'h00 || drive_sel_i == 4'h0;
endmodule
`default_nettype wire

// File: dv/pmr_seq_props.sv
/* pmr_seq_props: port checker for the pump motor sequencer.
   assumes one clock and the synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module pmr_seq_props
	import pmr_pkg::*;
#(
	parameter int N = 4
) (
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_i,
	// bus
	input wire logic         cyc_i,
	input wire logic         stb_i,
	input wire logic [31:0]  dat_o,
	input wire logic         ack_o,
	// drive and contactors
	input wire logic         run_cmd_i,
	input wire logic         alarm_i,
	input wire logic         drive_stopped_i,
	input wire logic         coast_stop_input_i,
	input wire logic [N-1:0] motor_drive_permit_i,
	input wire logic [N-1:0] motor_drive_fed_sel_o,
	input wire logic [N-1:0] motor_mains_fed_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==================================================================
	// steps
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_runoff;
		!run_cmd_i && drive_stopped_i;
	endsequence
	// ==================================================================
	// checks
	a_ack_answer: assert property (s_req |=> ack_o)
		else $error("request not acked");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	a_alarm_cut: assert property (alarm_i |=> motor_drive_fed_sel_o == '0)
		else $error("drive select kept on alarm");
	a_runoff_drop: assert property (s_runoff |=> motor_drive_fed_sel_o == '0)
		else $error("drive select kept after stop");
	a_coast_drop: assert property (coast_stop_input_i |=>
		motor_mains_fed_sel_o == '0 && motor_drive_fed_sel_o == '0)
		else $error("contactors kept on coast");
	a_permit_drop: assert property (1'b1 |=>
		(motor_mains_fed_sel_o & ~$past(motor_drive_permit_i)) == '0)
		else $error("mains kept without permit");
	a_drive_onehot: assert property ($onehot0(motor_drive_fed_sel_o))
		else $error("two drive-fed motors");
endmodule
bind pmr_seq pmr_seq_props #(.N(N)) u_props (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
	.run_cmd_i(run_cmd_i), .alarm_i(alarm_i), .drive_stopped_i(drive_stopped_i),
	.coast_stop_input_i(coast_stop_input_i),
	.motor_drive_permit_i(motor_drive_permit_i),
	.motor_drive_fed_sel_o(motor_drive_fed_sel_o),
	.motor_mains_fed_sel_o(motor_mains_fed_sel_o));
`default_nettype wire

// File: dv/test_pmr_seq.sv
/* test_pmr_seq: self-checking bench for the sequencer top.
   assumes 4 motors and a short tick divider to keep rotation brief. */
`timescale 1ns/100ps
`default_nettype none
module test_pmr_seq
	import pmr_pkg::*;
;
	// ==================================================================
	// signals
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fc;
	logic        run, alarm, stopped, add, shed, slow, coast;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i, permit, drv, mns;
	logic [31:0] dat_i, dat_o, rd;
	int          n_mismatch, checked, c;
	logic [39:0] rows [7] = '{40'h00_00000000, 40'h04_00000100,
		40'h08_00000000, 40'h0c_00000000, 40'h10_00000000,
		40'h14_00000000, 40'h40_00000000};
	pmr_seq #(.N(4), .TICK_DIV(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.run_cmd_i(run), .alarm_i(alarm), .drive_stopped_i(stopped),
		.motor_add_i(add), .motor_shed_i(shed), .slow_flow_stop_i(slow),
		.coast_stop_input_i(coast), .motor_drive_permit_i(permit),
		.motor_drive_fed_sel_o(drv), .motor_mains_fed_sel_o(mns),
		.switch_forecast_out_o(fc));
	pmr_drive_model #(.DECEL(8)) u_drive (.clk_i(clk_i), .rst_i(rst_i),
		.run_cmd_i(run), .alarm_i(alarm), .drive_sel_i(drv),
		.drive_stopped_o(stopped));
	// ==================================================================
	// tasks
	task automatic end_of_test;
		if (n_mismatch == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cs(input logic [7:0] e);
		chk({24'h0, drv, mns}, {24'h0, e});
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic pls(input logic [2:0] k);
		@(posedge clk_i);
		{add, shed, slow} <= k;
		@(posedge clk_i);
		{add, shed, slow} <= 3'h0;
		step(2);
	endtask
	task automatic halt;
		run <= 1'b0;
		c = 0;
		step(3);
		while (stopped !== 1'b1 && c < 50) begin
			step(1);
			c++;
		end
		step(2);
	endtask
	// ==================================================================
	// clock, watchdog
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		step(50000);
		n_mismatch++;
		end_of_test();
	end
	// ==================================================================
	// main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i, run, alarm, add, shed, slow, coast} = 10'h200;
		{adr_i, sel_i, dat_i, n_mismatch, checked} = '0;
		permit = 4'hf;
		step(16);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b0, rows[i][39:32], 32'h0);
			chk(rd, rows[i][31:0]);
		end
		wb(1'b1, OFS_MODE, 32'h55);
		wb(1'b1, OFS_CTRL, 32'h201);
		run <= 1'b1;
		pls(3'h4);
		cs(8'h10);
		pls(3'h4);
		cs(8'h21);
		pls(3'h4);
		cs(8'h43);
		pls(3'h2);
		cs(8'h41);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h201);
		// run off with stop setting 0: both dropped once the drive has stopped
		halt();
		cs(8'h00);
		wb(1'b1, OFS_SEQ, 32'h20);
		run <= 1'b1;
		pls(3'h4);
		pls(3'h4);
		alarm <= 1'b1;
		step(2);
		cs(8'h01);
		alarm <= 1'b0;
		coast <= 1'b1;
		step(2);
		cs(8'h00);
		coast <= 1'b0;
		wb(1'b1, OFS_SEQ, 32'h10);
		pls(3'h4);
		pls(3'h4);
		halt();
		cs(8'h01);
		alarm <= 1'b1;
		step(2);
		cs(8'h00);
		alarm <= 1'b0;
		run <= 1'b1;
		pls(3'h4);
		pls(3'h4);
		permit <= 4'he;
		step(2);
		cs(8'h20);
		permit <= 4'hf;
		coast <= 1'b1;
		step(2);
		coast <= 1'b0;
		// equal time: motor 3 never ran, motor 2 ran least of the rest
		wb(1'b1, OFS_SEQ, 32'h301);
		pls(3'h4);
		cs(8'h80);
		pls(3'h4);
		cs(8'h48);
		wb(1'b0, OFS_RT + 8'h0c, 32'h0);
		chk({31'h0, rd != 32'h0}, 32'h1);
		wb(1'b1, OFS_FCST, 32'h3);
		wb(1'b1, OFS_ROT, 32'h2706);
		c = 0;
		while (fc !== 1'b1 && c < 40000) begin
			step(1);
			c++;
		end
		chk({31'h0, c > 35000 && c < 40000}, 32'h1);
		c = 0;
		while (fc === 1'b1 && c < 20) begin
			step(1);
			c++;
		end
		chk({31'h0, c >= 4 && c <= 9}, 32'h1);
		cs(8'h28);
		// slow-flow stop moves the drive role: next in turn, then least run
		wb(1'b1, OFS_SEQ, 32'h302);
		pls(3'h1);
		cs(8'h48);
		wb(1'b1, OFS_SEQ, 32'h303);
		pls(3'h1);
		cs(8'h28);
		end_of_test();
	end
endmodule
`default_nettype wire
